// [verilog/pbd_beep.sv]
// Legacy tone activity detector, amplifier gating and digital beep top
`timescale 1ns/1ps
// Function
// - Link reset auto-routes tone to ports A, D
// - Link active: tone passes if enabled, output ports
// - Monitor runs when path enabled and D3
// - Sample 500us window every 1ms period
// - Window active at 37 percent or more
// - Window possibly inactive under 7.5 percent
// - Inactive after selectable 64 to 512ms idle
// - Auto phase: after 64ms, power then drive
// - Auto phase: idle threshold switches amplifiers off
// - Software disable does not stop auto-phase detection
// - D0-D2: unmute tone on detected activity
// - D3: power amplifiers of output ports
// - Amplifiers stay on until idle threshold passes
// - Tone equals sync rate over four times divider
// - Tone on output ports, others muted
// - Divider zero disables digital beep
// - Report clock stop not permitted in D3 while digital beep runs
module pbd_beep
  import pbd_pkg::*;
#(
  parameter int WIN_CYCLES = WIN_CYC,
  parameter int PER_CYCLES = PER_CYC,
  parameter int ACT_CYCLES = ACT_CYC,
  parameter int INACT_CYCLES = INACT_CYC,
  parameter int MS_CYCLES = PER_CYC,
  parameter int PWR_SETTLE = 16
) (
  // Core clock and reset
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // Link side
  input wire logic BIT_CLK,
  input wire logic LINK_RESETN,
  input wire logic SYNC,
  // Comparator level of the legacy tone input (asynchronous)
  input wire logic LEGACY_TONE_INPUT,
  // Software controls
  input wire logic BEEP_EN,
  input wire logic [1:0] IDLE_SEL,
  input wire logic [1:0] POWER_STATE,
  input wire logic [NPORT-1:0] PORT_OUT_EN,
  input wire logic [7:0] BEEP_DIV,
  // Port controls
  output logic [NPORT-1:0] PORT_PWD,
  output logic [NPORT-1:0] PORT_DRIVE_EN,
  output logic [NPORT-1:0] PORT_TONE_ROUTE,
  output logic [NPORT-1:0] PORT_DIG_TONE,
  output logic OTHER_SRC_MUTE,
  // Status
  output logic ANALOG_BEEP_EN,
  output logic BEEP_PRESENT,
  output logic CLK_STOP_OK
);
  import pbd_pkg::*;

  // Input synchronisers from pins and link domain
  logic [1:0] tone_s_reg, tone_s_next;
  logic [1:0] lrst_s_reg, lrst_s_next;
  logic [1:0] dact_s_reg, dact_s_next;
  logic [1:0] dtone_s_reg, dtone_s_next;
  logic lrst_sync, tone_lvl;
  // Link-side divider copy and status
  logic [7:0] div_s1_reg, div_s2_reg, div_s3_reg; // Divider synchroniser stages
  logic [7:0] div_l_reg;
  logic dig_tone, dig_active;
  // Window counters
  logic [16:0] per_reg, per_next; // Position within 1 ms period
  logic [16:0] hit_reg, hit_next; // High samples in window
  logic [16:0] ms_reg, ms_next; // Startup ms timer tick
  logic [9:0] idle_reg, idle_next; // Periods without activity
  logic [6:0] por_reg, por_next; // Startup ms count
  logic present_reg, present_next;
  logic auto_reg, auto_next; // Auto-routing phase flag
  logic seen_rst_reg, seen_rst_next;
  pbd_amp_t amp_reg, amp_next;
  logic [7:0] settle_reg, settle_next;
  logic mon_en, win_end, idle_hit, por_done;
  logic [9:0] idle_lim;

  // Map idle select to a count of 1 ms periods
  function automatic logic [9:0] idle_periods(input logic [1:0] sel);
    case (sel)
      2'h0: idle_periods = 10'(IDLE_MS_0);
      2'h1: idle_periods = 10'(IDLE_MS_1);
      2'h2: idle_periods = 10'(IDLE_MS_2);
      default: idle_periods = 10'(IDLE_MS_3);
    endcase
  endfunction

  // Divider crosses to the link clock as a quasi-static word: two flops per
  // bit, then the copy is only taken when two later samples agree, so a word
  // caught while the host rewrites it is never used by the generator
  always_ff @(posedge BIT_CLK or negedge LINK_RESETN) begin
    if (!LINK_RESETN) begin
      div_s1_reg <= DIV_RST;
      div_s2_reg <= DIV_RST;
      div_s3_reg <= DIV_RST;
      div_l_reg <= DIV_RST;
    end else begin
      div_s1_reg <= BEEP_DIV;
      div_s2_reg <= div_s1_reg;
      div_s3_reg <= div_s2_reg;
      // Stable word only; a mid-change mix of old and new bits is skipped
      if (div_s2_reg == div_s3_reg) begin
        div_l_reg <= div_s3_reg;
      end
    end
  end

  pbd_tone u_tone (
    .bit_clk(BIT_CLK),
    .link_rst_n(LINK_RESETN),
    .sync_pulse(SYNC),
    .divider(div_l_reg),
    .tone(dig_tone),
    .active(dig_active)
  );

  // Synchroniser next values; only stage two is read by logic
  always_comb begin
    tone_s_next = {tone_s_reg[0], LEGACY_TONE_INPUT};
    lrst_s_next = {lrst_s_reg[0], LINK_RESETN};
    dact_s_next = {dact_s_reg[0], dig_active};
    dtone_s_next = {dtone_s_reg[0], dig_tone};
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      tone_s_reg <= 2'h0;
      lrst_s_reg <= 2'h0;
      dact_s_reg <= 2'h0;
      dtone_s_reg <= 2'h0;
    end else begin
      tone_s_reg <= tone_s_next;
      lrst_s_reg <= lrst_s_next;
      dact_s_reg <= dact_s_next;
      dtone_s_reg <= dtone_s_next;
    end
  end

  assign lrst_sync = lrst_s_reg[1];
  assign tone_lvl = tone_s_reg[1];

  // Monitor runs in auto phase once the startup delay is done, or when enabled in D3
  always_comb begin
    if (auto_reg) begin
      mon_en = por_done;
    end else begin
      mon_en = BEEP_EN && (POWER_STATE == PS_D3);
    end
  end

  // Outside D3 with beep enabled activity still gates the unmute
  logic det_en;
  assign det_en = mon_en | (!auto_reg & BEEP_EN);
  assign por_done = (por_reg >= 7'(POR_DELAY_MS));
  assign win_end = (per_reg == 17'(WIN_CYCLES - 1));
  assign idle_lim = idle_periods(IDLE_SEL);
  assign idle_hit = (idle_reg >= idle_lim);

  // Window sampling, classification and idle timer
  always_comb begin
    per_next = per_reg;
    hit_next = hit_reg;
    idle_next = idle_reg;
    present_next = present_reg;
    if (!det_en) begin
      per_next = 17'h00000;
      hit_next = 17'h00000;
      idle_next = 10'h000;
      present_next = 1'b0;
    end else begin
      // Period counter wraps every 1 ms
      if (per_reg == 17'(PER_CYCLES - 1)) begin
        per_next = 17'h00000;
        hit_next = 17'h00000;
      end else begin
        per_next = per_reg + 17'h00001;
      end
      // Count samples only inside the window
      if (per_reg < 17'(WIN_CYCLES) && tone_lvl) begin
        hit_next = hit_reg + 17'h00001;
      end
      if (win_end) begin
        if (hit_next >= 17'(ACT_CYCLES)) begin
          present_next = 1'b1;
          idle_next = 10'h000;
        end else if (hit_next < 17'(INACT_CYCLES)) begin
          if (idle_hit) begin
            present_next = 1'b0;
          end else begin
            idle_next = idle_reg + 10'h001;
          end
        end
        // In-between windows hold state and timer
      end
    end
  end

  // Auto phase: lasts until first rising edge of link reset
  always_comb begin
    seen_rst_next = seen_rst_reg | lrst_sync;
    auto_next = auto_reg & ~lrst_sync;
    ms_next = ms_reg;
    por_next = por_reg;
    if (!por_done) begin
      if (ms_reg == 17'(MS_CYCLES - 1)) begin
        ms_next = 17'h00000;
        por_next = por_reg + 7'h01;
      end else begin
        ms_next = ms_reg + 17'h00001;
      end
    end
  end

  // Amplifier sequencer: release power-down, settle, then drive
  always_comb begin
    amp_next = amp_reg;
    settle_next = settle_reg;
    case (amp_reg)
      AMP_OFF: begin
        settle_next = 8'h00;
        if (present_reg) begin
          amp_next = AMP_PWR;
        end
      end
      AMP_PWR: begin
        if (!present_reg) begin
          amp_next = AMP_OFF;
        end else if (settle_reg == 8'(PWR_SETTLE - 1)) begin
          amp_next = AMP_ON;
        end else begin
          settle_next = settle_reg + 8'h01;
        end
      end
      AMP_ON: begin
        if (!present_reg) begin
          amp_next = AMP_OFF;
        end
      end
      default: amp_next = AMP_OFF;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      per_reg <= 17'h00000;
      hit_reg <= 17'h00000;
      idle_reg <= 10'h000;
      present_reg <= 1'b0;
      auto_reg <= 1'b1;
      seen_rst_reg <= 1'b0;
      ms_reg <= 17'h00000;
      por_reg <= 7'h00;
      amp_reg <= AMP_OFF;
      settle_reg <= 8'h00;
    end else begin
      per_reg <= per_next;
      hit_reg <= hit_next;
      idle_reg <= idle_next;
      present_reg <= present_next;
      auto_reg <= auto_next;
      seen_rst_reg <= seen_rst_next;
      ms_reg <= ms_next;
      por_reg <= por_next;
      amp_reg <= amp_next;
      settle_reg <= settle_next;
    end
  end

  // Port routing and amplifier enables
  logic [NPORT-1:0] tgt_ports;
  logic amp_need, dig_on;
  always_comb begin
    dig_on = dact_s_reg[1] & lrst_sync;
    if (auto_reg || !lrst_sync) begin
      tgt_ports = AUTO_PORTS;
    end else if (BEEP_EN) begin
      tgt_ports = PORT_OUT_EN;
    end else begin
      tgt_ports = '0;
    end
    // Amplifiers forced only in auto phase or D3; D0-D2 leave them on
    amp_need = auto_reg || (POWER_STATE == PS_D3);
  end

  // Per-port outputs
  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi++) begin : g_port
      always_comb begin
        // D0-D2: port stays powered, tone only unmuted on activity
        if (!amp_need) begin
          PORT_PWD[gi] = 1'b0;
          PORT_DRIVE_EN[gi] = PORT_OUT_EN[gi];
        end else begin
          PORT_PWD[gi] = !(tgt_ports[gi] && amp_reg != AMP_OFF);
          PORT_DRIVE_EN[gi] = tgt_ports[gi] && amp_reg == AMP_ON;
        end
        PORT_TONE_ROUTE[gi] = tgt_ports[gi] && present_reg && !dig_on;
        PORT_DIG_TONE[gi] = dig_on && PORT_OUT_EN[gi] && dtone_s_reg[1];
      end
    end
  endgenerate

  assign OTHER_SRC_MUTE = dig_on;
  assign ANALOG_BEEP_EN = (auto_reg && amp_reg == AMP_ON) || (!auto_reg && BEEP_EN && present_reg);
  assign BEEP_PRESENT = present_reg;
  assign CLK_STOP_OK = !(POWER_STATE == PS_D3 && dig_on);
endmodule

// [inc/pbd_pkg.sv]
// Package for the legacy tone detector and digital beep generator
package pbd_pkg;
  // Core clock rate in kHz
  localparam int CORE_KHZ = 125000;
  // Sampling window and period in microseconds
  localparam int WIN_US = 500;
  localparam int PER_US = 1000;
  // Cycle counts, window rounded down, period exact
  localparam int WIN_CYC = (WIN_US * CORE_KHZ) / 1000;
  localparam int PER_CYC = (PER_US * CORE_KHZ) / 1000;
  // Activity limits in tenths of a percent
  localparam int ACT_PERMIL = 370;
  localparam int INACT_PERMIL = 75;
  // Active needs at least this many high samples (round up)
  localparam int ACT_CYC = (WIN_CYC * ACT_PERMIL + 999) / 1000;
  // Possibly inactive when below this many samples
  localparam int INACT_CYC = (WIN_CYC * INACT_PERMIL) / 1000;
  // Idle thresholds in milliseconds, counted in 1 ms periods
  localparam int IDLE_MS_0 = 64;
  localparam int IDLE_MS_1 = 128;
  localparam int IDLE_MS_2 = 256;
  localparam int IDLE_MS_3 = 512;
  // Startup delay after power-on reset in milliseconds
  localparam int POR_DELAY_MS = 64;
  // Reset values
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [1:0] IDLE_SEL_RST = 2'h0;
  // Number of port pin complexes
  localparam int NPORT = 4;
  // Ports that receive auto-routed tone (A and D)
  localparam logic [NPORT-1:0] AUTO_PORTS = 4'h9;
  // Power states
  localparam logic [1:0] PS_D3 = 2'h3;
  // Auto-routing amplifier sequencer states
  typedef enum logic [1:0] {
    AMP_OFF = 2'b00,
    AMP_PWR = 2'b01,
    AMP_ON = 2'b11
  } pbd_amp_t;
endpackage

// [verilog/pbd_tone.sv]
// Digital beep tone generator on the link clock
`timescale 1ns/1ps
module pbd_tone (
  // Link clock and reset
  input wire logic bit_clk,
  input wire logic link_rst_n,
  // Frame sync and divider (divider already in this domain)
  input wire logic sync_pulse,
  input wire logic [7:0] divider,
  // Tone output and activity
  output logic tone,
  output logic active
);
  import pbd_pkg::*;

  logic sync_d_reg, sync_d_next;
  logic [9:0] cnt_reg, cnt_next; // Counts sync edges per half period
  logic tone_reg, tone_next;
  logic rise;
  logic [9:0] half;

  // Half period is twice the divider in sync pulses: f = sync / (4*div)
  always_comb begin
    rise = sync_pulse & ~sync_d_reg;
    half = {1'b0, divider, 1'b0};
    sync_d_next = sync_pulse;
    cnt_next = cnt_reg;
    tone_next = tone_reg;
    if (divider == 8'h00) begin
      cnt_next = 10'h000;
      tone_next = 1'b0;
    end else if (rise) begin
      if (cnt_reg + 10'h001 >= half) begin
        cnt_next = 10'h000;
        tone_next = ~tone_reg;
      end else begin
        cnt_next = cnt_reg + 10'h001;
      end
    end
  end

  // Register stage; link reset stops the generator
  always_ff @(posedge bit_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sync_d_reg <= 1'b0;
      cnt_reg <= 10'h000;
      tone_reg <= 1'b0;
    end else begin
      sync_d_reg <= sync_d_next;
      cnt_reg <= cnt_next;
      tone_reg <= tone_next;
    end
  end

  assign tone = tone_reg;
  assign active = (divider != 8'h00);
endmodule

// [test/pbd_beep_sva.sv]
// Port checker for the beep block
`timescale 1ns/1ps
module pbd_beep_sva
  import pbd_pkg::*;
(
  // Clock and resets
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic LINK_RESETN,
  // Controls
  input wire logic BEEP_EN,
  input wire logic [1:0] POWER_STATE,
  input wire logic [NPORT-1:0] PORT_OUT_EN,
  input wire logic [7:0] BEEP_DIV,
  // Outputs
  input wire logic [NPORT-1:0] PORT_PWD,
  input wire logic [NPORT-1:0] PORT_DRIVE_EN,
  input wire logic [NPORT-1:0] PORT_TONE_ROUTE,
  input wire logic [NPORT-1:0] PORT_DIG_TONE,
  input wire logic OTHER_SRC_MUTE,
  input wire logic BEEP_PRESENT,
  input wire logic CLK_STOP_OK
);
  // Auto phase seen at the pin; ends before the core's synced copy, so it errs safe
  logic auto_reg;
  logic auto_next;
  // Cycles the divider has read zero, saturating at 20
  logic [4:0] zc_reg;
  logic [4:0] zc_next;
  // Cycles the divider has read non-zero with the link up, saturating at 20
  logic [4:0] nz_reg;
  logic [4:0] nz_next;
  always_comb begin
    auto_next = auto_reg && !LINK_RESETN;
    zc_next = (BEEP_DIV != 8'h00) ? 5'h00 : zc_reg + {4'h0, zc_reg != 5'h14};
    nz_next = (BEEP_DIV == 8'h00 || !LINK_RESETN) ? 5'h00 : nz_reg + {4'h0, nz_reg != 5'h14};
  end
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      auto_reg <= 1'b1;
      zc_reg <= 5'h00;
      nz_reg <= 5'h00;
    end else begin
      auto_reg <= auto_next;
      zc_reg <= zc_next;
      nz_reg <= nz_next;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  // Disable held long enough for the synced auto flag to clear too
  sequence sw_off_s;
    (!auto_reg && !BEEP_EN) [*8];
  endsequence
  // Presence in D3 with the link up
  sequence d3_on_s;
    (!auto_reg && LINK_RESETN && BEEP_EN && POWER_STATE == PS_D3 && BEEP_PRESENT) [*8];
  endsequence
  auto_pwr_a:
    assert property (auto_reg && $rose(PORT_DRIVE_EN[0]) |-> $past(PORT_PWD[0], 8) == 1'b0)
    else $error("drive before power");
  auto_off_a:
    assert property (auto_reg && $fell(BEEP_PRESENT) |-> ##[0:40] PORT_DRIVE_EN == 4'h0)
    else $error("amps left on");
  link_route_a:
    assert property ((!auto_reg && !LINK_RESETN && !OTHER_SRC_MUTE) [*6] |-> PORT_TONE_ROUTE == AUTO_PORTS)
    else $error("link reset route");
  sw_off_a:
    assert property (sw_off_s |-> !BEEP_PRESENT) else $error("detect while off");
  d3_pwr_a:
    assert property (d3_on_s |-> (PORT_PWD & PORT_OUT_EN) == 4'h0) else $error("d3 port down");
  // A divider held non-zero long enough to reach the core side must hold the clock
  clk_stop_a:
    assert property (POWER_STATE == PS_D3 && nz_reg == 5'h14 |-> !CLK_STOP_OK) else $error("clock stop");
  div_off_a:
    assert property (zc_reg == 5'h14 |-> !OTHER_SRC_MUTE && PORT_DIG_TONE == 4'h0) else $error("tone at zero");
  tone_port_a:
    assert property ($stable(PORT_OUT_EN) [*4] |-> (PORT_DIG_TONE & ~PORT_OUT_EN) == 4'h0)
    else $error("tone on input port");
endmodule
bind pbd_beep pbd_beep_sva pbd_beep_sva_inst (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .LINK_RESETN(LINK_RESETN),
  .BEEP_EN(BEEP_EN), .POWER_STATE(POWER_STATE), .PORT_OUT_EN(PORT_OUT_EN), .BEEP_DIV(BEEP_DIV),
  .PORT_PWD(PORT_PWD), .PORT_DRIVE_EN(PORT_DRIVE_EN), .PORT_TONE_ROUTE(PORT_TONE_ROUTE),
  .PORT_DIG_TONE(PORT_DIG_TONE), .OTHER_SRC_MUTE(OTHER_SRC_MUTE), .BEEP_PRESENT(BEEP_PRESENT),
  .CLK_STOP_OK(CLK_STOP_OK));

// [test/pbd_host.sv]
// Link host model: free bit clock, frame sync, link reset
`timescale 1ns/1ps
module pbd_host #(
  parameter int FRAME_BCLK = 8
) (
  // Link reset request from the bench
  input wire logic hold_rst,
  // Link pins
  output logic bit_clk,
  output logic link_rst_n,
  output logic sync
);
  int cnt;
  // Odd start offset keeps the link clock out of phase with the core
  initial begin
    link_rst_n = 1'b0;
    sync = 1'b0;
    cnt = 0;
    bit_clk = 1'b0;
    #1.7;
    forever #6 bit_clk = ~bit_clk;
  end
  // Short frames keep tone periods quick to measure
  always @(posedge bit_clk) begin
    cnt <= (cnt == FRAME_BCLK - 1) ? 0 : cnt + 1;
    sync <= (cnt == 0);
    link_rst_n <= !hold_rst;
  end
endmodule

// [test/pbd_beep_tb_top.sv]
// Self-checking bench for the beep block
`timescale 1ns/1ps
module pbd_beep_tb_top;
  import pbd_pkg::*;
  // One period in core cycles
  localparam int PER = 100;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tin = 1'b0;
  logic en = 1'b0;
  logic [1:0] isel = 2'h0;
  logic [1:0] ps = 2'h0;
  logic [NPORT-1:0] oen = 4'hF;
  logic [7:0] div = 8'h00;
  logic hold = 1'b1;
  logic bclk, lrst_n, sync, mute, aen, pres, cso;
  logic [NPORT-1:0] pwd, drv, rte, dtn;
  int n_errors = 0;
  int total_checks = 0;
  int k;
  always #4 clk = ~clk;
  pbd_host pbd_host_inst (.hold_rst(hold), .bit_clk(bclk), .link_rst_n(lrst_n), .sync(sync));
  pbd_beep #(.WIN_CYCLES(50), .PER_CYCLES(PER), .ACT_CYCLES(19), .INACT_CYCLES(3), .MS_CYCLES(PER)) pbd_beep_inst (
    .CORE_CLK(clk), .RESETN(rst_n), .BIT_CLK(bclk), .LINK_RESETN(lrst_n), .SYNC(sync), .LEGACY_TONE_INPUT(tin),
    .BEEP_EN(en), .IDLE_SEL(isel), .POWER_STATE(ps), .PORT_OUT_EN(oen), .BEEP_DIV(div), .PORT_PWD(pwd),
    .PORT_DRIVE_EN(drv), .PORT_TONE_ROUTE(rte), .PORT_DIG_TONE(dtn), .OTHER_SRC_MUTE(mute),
    .ANALOG_BEEP_EN(aen), .BEEP_PRESENT(pres), .CLK_STOP_OK(cso));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %h %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("MISMATCH %0t %h %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic test_done;
    if (n_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // A bounded wait that ran out ends the run
  task automatic tmo;
    if (k == 0) begin
      chk(8'h00, 8'h01);
      test_done();
    end
  endtask
  // Comparator high one cycle in every n
  task automatic tone(input int cycles, input int n);
    for (int i = 0; i < cycles; i++) begin
      tin = (i % n == 0);
      @(negedge clk);
    end
  endtask
  task automatic wait_tone(input logic [NPORT-1:0] v);
    for (k = 200; k > 0 && dtn !== v; k--) @(negedge clk);
    tmo();
  endtask
  // Auto phase: deaf before the startup delay, then A and D, then idle off
  task automatic t_auto;
    tone(30 * PER, 1);
    chk(pres, 1'b0);
    tone(43 * PER, 200);
    for (k = 3 * PER; k > 0 && drv !== AUTO_PORTS; k--) tone(1, 1);
    tmo();
    chk(pwd & AUTO_PORTS, 4'h0);
    chk(aen, 1'b1);
    tin = 1'b0;
    for (k = 70 * PER; k > 0 && drv !== 4'h0; k--) @(negedge clk);
    tmo();
    chk_rng(70 * PER - k, 62 * PER, 68 * PER);
  endtask
  // D0: unmute on presence; middling windows must not age the timer
  task automatic t_idle;
    isel = 2'h1;
    en = 1'b1;
    tone(4 * PER, 1);
    chk(pres, 1'b1);
    chk(rte, oen);
    tone(150 * PER, 10);
    chk(pres, 1'b1);
    // Quiet windows: one high sample in 50, well under the inactive limit
    for (k = 140 * PER; k > 0 && pres !== 1'b0; k--) begin
      tin = (k % 50 == 0);
      @(negedge clk);
    end
    tmo();
    chk_rng(140 * PER - k, 126 * PER, 131 * PER);
    tone(10, 2000);
    chk(rte, 4'h0);
  endtask
  // Disabled by software: no detection, no route
  task automatic t_off;
    en = 1'b0;
    tone(4 * PER, 1);
    chk(pres, 1'b0);
    chk(rte, 4'h0);
  endtask
  // D3: presence powers output ports and drives only output ports
  task automatic t_d3;
    en = 1'b1;
    ps = PS_D3;
    oen = 4'h5;
    tone(4 * PER, 1);
    chk(pres, 1'b1);
    chk(pwd & 4'h5, 4'h0);
    chk(drv, 4'h5);
    tin = 1'b0;
  endtask
  // Digital tone for two dividers, then zero stops it
  task automatic t_dig;
    for (int d = 1; d <= 2; d++) begin
      div = 8'(d);
      wait_tone(4'h0);
      wait_tone(4'h5);
      chk(mute, 1'b1);
      chk(cso, 1'b0);
      wait_tone(4'h0);
      chk_rng(200 - k, 24 * d - 2, 24 * d + 2);
    end
    div = 8'h00;
    repeat (40) @(negedge clk);
    chk(mute, 1'b0);
    chk(dtn, 4'h0);
    chk(cso, 1'b1);
    chk(drv, 4'h5);
    hold = 1'b1;
    repeat (20) @(negedge clk);
    chk(rte, AUTO_PORTS);
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_auto();
    hold = 1'b0;
    repeat (10) @(negedge clk);
    t_idle();
    t_off();
    t_d3();
    t_dig();
    test_done();
  end
endmodule
